/* File: shared/psw_consts.vh */
`ifndef PSW_CONSTS_VH
`define PSW_CONSTS_VH

// ----------------------------------------
// register map (avalon word addresses)
// ----------------------------------------
`define PSW_ADDR_W 8
`define PSW_OFS_STATUS 8'hD0
`define PSW_OFS_PAGE_CTRL 8'hD4
`define PSW_OFS_PAGE_SEL 8'hD8

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define PSW_BIT_CARRY 7
`define PSW_BIT_HALF 6
`define PSW_BIT_USER_A 5
`define PSW_BIT_BANK_HI 4
`define PSW_BIT_BANK_LO 3
`define PSW_BIT_OVF 2
`define PSW_BIT_USER_B 1
`define PSW_BIT_PARITY 0

// ----------------------------------------
// reset values and operation codes
// ----------------------------------------
`define PSW_STATUS_RST 8'h00
`define PSW_PAGE_EN_RST 1'h1
`define PSW_PAGE_SEL_RST 8'h00
`define PSW_BYTE_MAX 16'h00FF
`define PSW_OP_NONE 3'h0
`define PSW_OP_ADD 3'h1
`define PSW_OP_ADD_CARRY_INSTR 3'h2
`define PSW_OP_SUB_BORROW_INSTR 3'h3
`define PSW_OP_MUL 3'h4
`define PSW_OP_DIV 3'h5
`define PSW_BANK_SHIFT 3

`endif

/* File: verilog/psw_ovf_calc.v */
`timescale 1ns/100ps
`include "psw_consts.vh"

module psw_ovf_calc
(
  // operation
  input wire [2:0] i_op,
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  input wire i_cin,
  // result
  output reg o_touch,
  output reg o_ovf
);

  reg [8:0] sum;
  reg [8:0] dif;
  reg [15:0] prod;
  wire carry_in;

  // plain add ignores the carry; add-with-carry folds it in here, and subtract-with-borrow folds it in below
  assign carry_in = (i_op == `PSW_OP_ADD_CARRY_INSTR) & i_cin;

  always @*
  begin
    sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, carry_in};
    dif = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
    prod = {8'h00, i_a} * {8'h00, i_b};
    o_touch = 1'b1;
    o_ovf = 1'b0;
    case (i_op)
      `PSW_OP_ADD, `PSW_OP_ADD_CARRY_INSTR:
        o_ovf = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
      `PSW_OP_SUB_BORROW_INSTR:
        o_ovf = (i_a[7] != i_b[7]) && (dif[7] != i_a[7]);
      `PSW_OP_MUL:
        o_ovf = prod > `PSW_BYTE_MAX;
      `PSW_OP_DIV:
        o_ovf = (i_b == 8'h00);
      default:
        o_touch = 1'b0;
    endcase
  end

endmodule // psw_ovf_calc

/* File: verilog/psw_bank_map.v */
`timescale 1ns/100ps
`include "psw_consts.vh"

module psw_bank_map
(
  // register select
  input wire [1:0] i_bank,
  input wire [2:0] i_reg,
  // data address
  output wire [7:0] o_addr
);

  // bank n covers 8n..8n+7
  assign o_addr = {3'h0, i_bank, i_reg};

endmodule // psw_bank_map

/* File: verilog/psw_status_word.v */
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "psw_consts.vh"

module psw_status_word
(
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // avalon-mm slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // core flag updates
  input wire [2:0] i_alu_op,
  input wire [7:0] i_alu_a,
  input wire [7:0] i_alu_b,
  input wire i_alu_cin,
  input wire i_carry_wr,
  input wire i_carry_val,
  input wire i_half_wr,
  input wire i_half_val,
  input wire [7:0] i_acc,
  // single-bit access
  input wire i_bit_wr,
  input wire [2:0] i_bit_idx,
  input wire i_bit_val,
  // working register select
  input wire [2:0] i_reg_idx,
  // status outputs
  output reg [7:0] o_status,
  output reg [1:0] o_bank_select,
  output reg [7:0] o_reg_addr,
  output reg o_page_switch_enable,
  output reg [7:0] o_register_page_select
);

  // ----------------------------------------
  // flag state
  // ----------------------------------------
  reg carry_flag_ff;
  reg half_carry_flag_ff;
  reg user_flag_a_ff;
  reg [1:0] bank_select_ff;
  reg overflow_flag_ff;
  reg user_flag_b_ff;
  reg page_switch_enable_ff;
  reg [7:0] register_page_select_ff;
  reg nxt_carry;
  reg nxt_half;
  reg nxt_user_a;
  reg [1:0] nxt_bank;
  reg nxt_ovf;
  reg nxt_user_b;
  reg [7:0] nxt_image;
  wire ovf_touch;
  wire ovf_val;
  wire [7:0] reg_addr;
  wire parity_now;
  wire bus_req;
  wire wr_status;

  assign parity_now = ^i_acc;

  psw_ovf_calc u_ovf
  (
    .i_op(i_alu_op),
    .i_a(i_alu_a),
    .i_b(i_alu_b),
    .i_cin(i_alu_cin),
    .o_touch(ovf_touch),
    .o_ovf(ovf_val)
  );

  psw_bank_map u_bank
  (
    .i_bank(nxt_bank),
    .i_reg(i_reg_idx),
    .o_addr(reg_addr)
  );

  // ----------------------------------------
  // bus handshake: one wait cycle, then answer
  // ----------------------------------------
  assign bus_req = (i_avs_read | i_avs_write) & o_avs_waitrequest;
  assign wr_status = i_avs_write & ~o_avs_waitrequest
    & (i_avs_address == `PSW_OFS_STATUS);

  function [7:0] read_mux;
    input [7:0] addr;
    input [7:0] image;
    input pen;
    input [7:0] psel;
    begin
      if (addr == `PSW_OFS_STATUS)
        read_mux = image;
      else if (addr == `PSW_OFS_PAGE_CTRL)
        read_mux = {7'h00, pen};
      else if (addr == `PSW_OFS_PAGE_SEL)
        read_mux = psel;
      else
        read_mux = 8'h00;
    end
  endfunction

  // ----------------------------------------
  // next flag values
  // ----------------------------------------
  always @*
  begin
    nxt_carry = carry_flag_ff;
    nxt_half = half_carry_flag_ff;
    nxt_user_a = user_flag_a_ff;
    nxt_bank = bank_select_ff;
    nxt_ovf = overflow_flag_ff;
    nxt_user_b = user_flag_b_ff;
    // software byte write, every bit except parity
    if (wr_status)
    begin
      nxt_carry = i_avs_writedata[`PSW_BIT_CARRY];
      nxt_half = i_avs_writedata[`PSW_BIT_HALF];
      nxt_user_a = i_avs_writedata[`PSW_BIT_USER_A];
      nxt_bank = i_avs_writedata[`PSW_BIT_BANK_HI:`PSW_BIT_BANK_LO];
      nxt_ovf = i_avs_writedata[`PSW_BIT_OVF];
      nxt_user_b = i_avs_writedata[`PSW_BIT_USER_B];
    end
    // single-bit write, bit-addressable access
    if (i_bit_wr)
    begin
      case (i_bit_idx)
        `PSW_BIT_CARRY: nxt_carry = i_bit_val;
        `PSW_BIT_HALF: nxt_half = i_bit_val;
        `PSW_BIT_USER_A: nxt_user_a = i_bit_val;
        `PSW_BIT_BANK_HI: nxt_bank[1] = i_bit_val;
        `PSW_BIT_BANK_LO: nxt_bank[0] = i_bit_val;
        `PSW_BIT_OVF: nxt_ovf = i_bit_val;
        `PSW_BIT_USER_B: nxt_user_b = i_bit_val;
        default: nxt_ovf = nxt_ovf;
      endcase
    end
    // core updates take priority over software
    if (i_carry_wr)
      nxt_carry = i_carry_val;
    if (i_half_wr)
      nxt_half = i_half_val;
    if (ovf_touch)
      nxt_ovf = ovf_val;
    nxt_image = {nxt_carry, nxt_half, nxt_user_a, nxt_bank, nxt_ovf, nxt_user_b, parity_now};
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      carry_flag_ff <= 1'h0;
      half_carry_flag_ff <= 1'h0;
      user_flag_a_ff <= 1'h0;
      bank_select_ff <= 2'h0;
      overflow_flag_ff <= 1'h0;
      user_flag_b_ff <= 1'h0;
      page_switch_enable_ff <= `PSW_PAGE_EN_RST;
      register_page_select_ff <= `PSW_PAGE_SEL_RST;
      o_avs_waitrequest <= 1'h1;
      o_avs_readdata <= 32'h00000000;
      o_status <= `PSW_STATUS_RST;
      o_bank_select <= 2'h0;
      o_reg_addr <= 8'h00;
      o_page_switch_enable <= `PSW_PAGE_EN_RST;
      o_register_page_select <= `PSW_PAGE_SEL_RST;
    end
    else
    begin
      carry_flag_ff <= nxt_carry;
      half_carry_flag_ff <= nxt_half;
      user_flag_a_ff <= nxt_user_a;
      bank_select_ff <= nxt_bank;
      overflow_flag_ff <= nxt_ovf;
      user_flag_b_ff <= nxt_user_b;
      if (i_avs_write & ~o_avs_waitrequest)
      begin
        if (i_avs_address == `PSW_OFS_PAGE_CTRL)
          page_switch_enable_ff <= i_avs_writedata[0];
        else if (i_avs_address == `PSW_OFS_PAGE_SEL)
          register_page_select_ff <= i_avs_writedata[7:0];
      end
      o_avs_waitrequest <= ~bus_req;
      if (bus_req & i_avs_read)
        o_avs_readdata <= {24'h000000, read_mux(i_avs_address, nxt_image,
          page_switch_enable_ff, register_page_select_ff)};
      o_status <= nxt_image;
      o_bank_select <= nxt_bank;
      o_reg_addr <= reg_addr;
      o_page_switch_enable <= page_switch_enable_ff;
      o_register_page_select <= register_page_select_ff;
    end
  end

endmodule // psw_status_word

/* File: testbench/psw_status_word_assertions.sv */
`timescale 1ns/100ps
`include "psw_consts.vh"
module psw_status_word_assertions
(
  // bus side
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  // core side
  input wire [2:0] i_alu_op,
  input wire [7:0] i_alu_a,
  input wire [7:0] i_alu_b,
  input wire i_alu_cin,
  input wire i_bit_wr,
  input wire [2:0] i_reg_idx,
  input wire [7:0] o_status,
  input wire [1:0] o_bank_select,
  input wire [7:0] o_reg_addr,
  input wire o_page_switch_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire [8:0] sum = {1'h0, i_alu_a} + {1'h0, i_alu_b} + {8'h00, i_alu_op == `PSW_OP_ADD_CARRY_INSTR && i_alu_cin};
  wire [8:0] dif = {1'h0, i_alu_a} - {1'h0, i_alu_b} - {8'h00, i_alu_cin};
  wire ov_add = (i_alu_a[7] == i_alu_b[7]) && (sum[7] != i_alu_a[7]);
  wire ov_sub = (i_alu_a[7] != i_alu_b[7]) && (dif[7] != i_alu_a[7]);
  wire [15:0] prod = {8'h00, i_alu_a} * {8'h00, i_alu_b};
  add_ovf_a: assert property ((i_alu_op == `PSW_OP_ADD || i_alu_op == `PSW_OP_ADD_CARRY_INSTR) |=>
    o_status[2] == $past(ov_add)) else $error("add overflow wrong");
  sub_borrow_instr_ovf_a: assert property (i_alu_op == `PSW_OP_SUB_BORROW_INSTR |=> o_status[2] == $past(ov_sub))
    else $error("subtract overflow wrong");
  mul_ovf_a: assert property (i_alu_op == `PSW_OP_MUL |=> o_status[2] == $past(prod > `PSW_BYTE_MAX))
    else $error("multiply overflow wrong");
  div_ovf_a: assert property (i_alu_op == `PSW_OP_DIV |=> o_status[2] == $past(i_alu_b == 8'h00))
    else $error("divide overflow wrong");
  user_flag_hold_a: assert property (!i_bit_wr && !i_avs_write && !$past(i_avs_write) |=>
    $stable({o_status[5], o_status[1]})) else $error("user flag changed");
  bank_addr_a: assert property (!$past(i_rst) && $stable(o_bank_select) |->
    o_reg_addr == {3'h0, o_bank_select, $past(i_reg_idx)}) else $error("bank address wrong");
  bank_mirror_a: assert property (o_bank_select == o_status[4:3]) else $error("bank select mismatch");
  page_en_rst_a: assert property ($past(i_rst) |-> o_page_switch_enable) else $error("page switch off");
  rd_status_a: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address == `PSW_OFS_STATUS
    && $stable(o_status) |-> o_avs_readdata == {24'h000000, o_status}) else $error("status read wrong");
  ack_once_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer wrong");
  cover property (i_alu_op == `PSW_OP_MUL ##1 o_status[2]);
  cover property (i_alu_op == `PSW_OP_DIV && i_alu_b == 8'h00);
  cover property (!o_avs_waitrequest && i_avs_write);
  cover property (i_bit_wr);
endmodule // psw_status_word_assertions
bind psw_status_word psw_status_word_assertions i_chk (.i_clk, .i_rst, .i_avs_address, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_alu_op, .i_alu_a, .i_alu_b, .i_alu_cin,
  .i_bit_wr, .i_reg_idx, .o_status, .o_bank_select, .o_reg_addr, .o_page_switch_enable);

/* File: testbench/psw_tb.sv */
`timescale 1ns/100ps
`include "psw_consts.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'h0, i_avs_write = 1'h0, i_alu_cin = 1'h0, i_bit_wr = 1'h0, i_bit_val = 1'h0;
  logic i_carry_wr = 1'h0, i_carry_val = 1'h0, i_half_wr = 1'h0, i_half_val = 1'h0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [2:0] i_alu_op = 3'h0, i_bit_idx = 3'h0, i_reg_idx = 3'h5;
  logic [7:0] i_alu_a = 8'h00, i_alu_b = 8'h00, i_acc = 8'h00;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest, o_page_switch_enable;
  wire [7:0] o_status, o_reg_addr, o_register_page_select;
  wire [1:0] o_bank_select;
  int err_count = 0, checks_done = 0, n;
  logic [31:0] q;
  psw_status_word i_dut (.i_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .i_alu_op, .i_alu_a, .i_alu_b, .i_alu_cin, .i_carry_wr,
    .i_carry_val, .i_half_wr, .i_half_val, .i_acc, .i_bit_wr, .i_bit_idx, .i_bit_val, .i_reg_idx,
    .o_status, .o_bank_select, .o_reg_addr, .o_page_switch_enable, .o_register_page_select);
  initial forever #10 i_clk = ~i_clk;
  // ----------------------------------------
  // bus and core tasks
  // ----------------------------------------
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    n = 0;
    do begin @(posedge i_clk); n++; end while (o_avs_waitrequest !== 1'h0 && n < 50);
    q = o_avs_readdata;
    i_avs_read <= 1'h0;
    i_avs_write <= 1'h0;
    if (n >= 50)
    begin
      err_count++;
      tally_and_finish;
    end
  endtask
  task op(input logic [2:0] c, input logic [7:0] a, b, input logic ci, e);
    @(posedge i_clk);
    i_alu_op <= c;
    i_alu_a <= a;
    i_alu_b <= b;
    i_alu_cin <= ci;
    @(posedge i_clk);
    i_alu_op <= `PSW_OP_NONE;
    #1;
    `CHK(o_status[2], e)
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'h0;
    av(1'h0, `PSW_OFS_PAGE_CTRL, 32'h0);
    `CHK(q[0], 1'h1)
    av(1'h0, `PSW_OFS_STATUS, 32'h0);
    `CHK(q, 32'h0)
    av(1'h1, 8'h40, 32'hFF);
    av(1'h0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    for (int k = 0; k < 4; k++)
    begin
      av(1'h1, `PSW_OFS_STATUS, 32'(k << 3) | 32'h22);
      repeat (3) @(posedge i_clk);
      #1;
      `CHK(o_reg_addr, 8'(k * 8 + 5))
    end
    `CHK(o_bank_select, 2'h3)
    av(1'h0, `PSW_OFS_STATUS, 32'h0);
    `CHK(q, 32'h3A)
    `CHK(o_page_switch_enable, 1'h1)
    av(1'h1, `PSW_OFS_PAGE_SEL, 32'h0C);
    av(1'h0, `PSW_OFS_PAGE_SEL, 32'h0);
    `CHK(q, 32'h0C)
    `CHK(o_register_page_select, 8'h0C)
    op(`PSW_OP_ADD, 8'h7F, 8'h00, 1'h1, 1'h0);
    op(`PSW_OP_ADD, 8'h7F, 8'h01, 1'h0, 1'h1);
    op(`PSW_OP_ADD, 8'h01, 8'h01, 1'h1, 1'h0);
    op(`PSW_OP_ADD_CARRY_INSTR, 8'h7F, 8'h00, 1'h1, 1'h1);
    op(`PSW_OP_SUB_BORROW_INSTR, 8'h80, 8'h01, 1'h0, 1'h1);
    op(`PSW_OP_SUB_BORROW_INSTR, 8'h05, 8'h01, 1'h1, 1'h0);
    op(`PSW_OP_MUL, 8'h10, 8'h10, 1'h0, 1'h1);
    op(`PSW_OP_MUL, 8'h0F, 8'h11, 1'h0, 1'h0);
    op(`PSW_OP_DIV, 8'h07, 8'h00, 1'h0, 1'h1);
    op(`PSW_OP_DIV, 8'h07, 8'h03, 1'h0, 1'h0);
    `CHK({o_status[5], o_status[1]}, 2'h3)
    @(posedge i_clk);
    i_bit_wr <= 1'h1;
    i_bit_idx <= 3'h5;
    i_bit_val <= 1'h0;
    @(posedge i_clk);
    i_bit_idx <= 3'h2;
    i_bit_val <= 1'h1;
    @(posedge i_clk);
    i_bit_wr <= 1'h0;
    av(1'h0, `PSW_OFS_STATUS, 32'h0);
    `CHK(q, 32'h1E)
    i_acc <= 8'h07;
    i_carry_wr <= 1'h1;
    i_carry_val <= 1'h1;
    @(posedge i_clk);
    i_carry_wr <= 1'h0;
    @(posedge i_clk);
    #1;
    `CHK({o_status[7], o_status[0]}, 2'h3)
    op(`PSW_OP_ADD, 8'h01, 8'h01, 1'h0, 1'h0);
    tally_and_finish;
  end
endmodule // testbench
